// >>> logic/wsse_regs.vh
/*
  constants for the weld sequence step engine: opcodes, entry layout,
  delay timing. assumes a 25 MHz system clock.
*/
`ifndef WSSE_REGS_VH
`define WSSE_REGS_VH
`define WSSE_OP_NOP 8'h00
`define WSSE_OP_SW_ON 8'h01
`define WSSE_OP_SW_OFF 8'h02
`define WSSE_OP_RLY_SET 8'h03
`define WSSE_OP_RLY_CLR 8'h04
`define WSSE_OP_DELAY 8'h05
`define WSSE_OP_DAC1 8'h06
`define WSSE_OP_DAC2 8'h07
`define WSSE_OP_DAC3 8'h08
`define WSSE_OP_DAC4 8'h09
`define WSSE_OP_WELD 8'h0a
`define WSSE_ENT_OP_MSB 23
`define WSSE_ENT_OP_LSB 16
`define WSSE_ENT_HI_MSB 15
`define WSSE_ENT_HI_LSB 8
`define WSSE_ENT_LO_MSB 7
`define WSSE_ENT_LO_LSB 0
`define WSSE_DAC_MSB 11
`define WSSE_CLK_HZ 25000000
`define WSSE_TICK_MS 10
`define WSSE_TICK_CYC ((`WSSE_CLK_HZ / 1000) * `WSSE_TICK_MS)
`define WSSE_RST_RELAY 8'h00
`define WSSE_RST_DAC 12'h000
`endif

// >>> logic/wsse_tick.v
/*
  tick divider: one-cycle enable pulse every DIV clocks while run is high.
  assumes synchronous active-high reset on the single system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wsse_tick #(
  parameter DIV = 250000
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  output wire tick_o
);
  reg [31:0] cnt_ff;
  wire [31:0] nxt_cnt;
  // restart on every new delay so the first tick is a full period away
  assign nxt_cnt = (!run_i || cnt_ff == DIV - 1) ? 32'h0 : cnt_ff + 32'h1;
  assign tick_o = run_i && (cnt_ff == DIV - 1);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // wsse_tick
`default_nettype wire

// >>> logic/wsse_engine.v
/*
  weld sequence step engine: fetches 3-byte program entries and executes
  opcodes 0 to 10, driving relays, four converters and a weld start pulse.
  assumes the program store answers a fetch with a valid strobe, and that
  switch inputs are already synchronous to CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wsse_regs.vh"
module wsse_engine #(
  parameter STEP_W = 8,
  parameter TICK_CYC = `WSSE_TICK_CYC
) (
  input wire CLK_I,
  input wire RST_I,
  input wire RUN_I,
  input wire [7:0] SWITCH_INPUT_I,
  output wire [STEP_W-1:0] FETCH_ADDR_O,
  output wire FETCH_REQ_O,
  input wire FETCH_VALID_I,
  input wire [23:0] FETCH_ENTRY_I,
  output wire [STEP_W-1:0] PROGRAM_STEP_O,
  output wire [7:0] RELAY_OUTPUT_O,
  output wire [11:0] DAC1_O,
  output wire [11:0] DAC2_O,
  output wire [11:0] DAC3_O,
  output wire [11:0] DAC4_O,
  output wire [3:0] DAC_LOAD_O,
  output wire WELD_START_O,
  output wire WELD_USE_ACTIVE_O,
  output wire [7:0] WELD_SCHED_O,
  output wire BAD_OP_O,
  output wire BUSY_O
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_EXEC = 4'b0100;
  localparam [3:0] ST_DELAY = 4'b1000;

  reg [3:0] state_ff, nxt_state;
  reg [STEP_W-1:0] step_ff, nxt_step;
  reg [7:0] op_ff, nxt_op;
  reg [15:0] val_ff, nxt_val;
  reg [15:0] dly_ff, nxt_dly;
  reg [7:0] relay_ff, nxt_relay;
  reg [11:0] dac1_ff, dac2_ff, dac3_ff, dac4_ff;
  reg [3:0] dac_ld_ff, nxt_dac_ld;
  reg weld_ff, nxt_weld;
  reg weld_act_ff, nxt_weld_act;
  reg [7:0] sched_ff, nxt_sched;
  reg bad_ff, nxt_bad;
  reg sw_sel;
  integer i;
  wire tick;
  wire [7:0] hi_b;
  wire [7:0] lo_b;
  wire [STEP_W-1:0] step_inc;
  wire [STEP_W-1:0] target;

  assign hi_b = val_ff[15:8];
  assign lo_b = val_ff[7:0];
  assign step_inc = step_ff + {{(STEP_W-1){1'b0}}, 1'b1};
  assign target = hi_b[STEP_W-1:0];

  wsse_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .run_i(state_ff == ST_DELAY),
    .tick_o(tick)
  );

  // lowest set select bit picks the input; no bit set reads as off
  always @* begin
    sw_sel = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (lo_b[i]) begin
        sw_sel = SWITCH_INPUT_I[i];
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_op = op_ff;
    nxt_val = val_ff;
    nxt_dly = dly_ff;
    nxt_relay = relay_ff;
    nxt_dac_ld = 4'h0;
    nxt_weld = 1'b0;
    nxt_weld_act = weld_act_ff;
    nxt_sched = sched_ff;
    nxt_bad = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (RUN_I) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!RUN_I) begin
          nxt_state = ST_IDLE;
        end else if (FETCH_VALID_I) begin
          nxt_op = FETCH_ENTRY_I[`WSSE_ENT_OP_MSB:`WSSE_ENT_OP_LSB];
          nxt_val = {FETCH_ENTRY_I[`WSSE_ENT_HI_MSB:`WSSE_ENT_HI_LSB],
                     FETCH_ENTRY_I[`WSSE_ENT_LO_MSB:`WSSE_ENT_LO_LSB]};
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = ST_FETCH;
        nxt_step = step_inc;
        case (op_ff)
          `WSSE_OP_NOP: begin
            nxt_step = step_inc;
          end
          `WSSE_OP_SW_ON: begin
            if (hi_b != 8'h00) begin
              if (!sw_sel) begin
                nxt_step = target;
              end
            end else if (!sw_sel) begin
              nxt_step = step_ff;
              nxt_state = ST_EXEC;
            end
          end
          `WSSE_OP_SW_OFF: begin
            if (hi_b != 8'h00) begin
              if (sw_sel) begin
                nxt_step = target;
              end
            end else if (sw_sel) begin
              nxt_step = step_ff;
              nxt_state = ST_EXEC;
            end
          end
          `WSSE_OP_RLY_SET: begin
            nxt_relay = relay_ff | lo_b;
          end
          `WSSE_OP_RLY_CLR: begin
            nxt_relay = relay_ff & ~lo_b;
          end
          `WSSE_OP_DELAY: begin
            nxt_step = step_ff;
            if (val_ff == 16'h0000) begin
              nxt_step = step_inc;
            end else begin
              nxt_dly = val_ff;
              nxt_state = ST_DELAY;
            end
          end
          `WSSE_OP_DAC1: nxt_dac_ld = 4'h1;
          `WSSE_OP_DAC2: nxt_dac_ld = 4'h2;
          `WSSE_OP_DAC3: nxt_dac_ld = 4'h4;
          `WSSE_OP_DAC4: nxt_dac_ld = 4'h8;
          `WSSE_OP_WELD: begin
            nxt_weld = 1'b1;
            nxt_weld_act = (lo_b == 8'h00);
            if (lo_b != 8'h00) begin
              nxt_sched = lo_b;
            end
          end
          default: begin
            // unsupported opcodes are skipped and flagged
            nxt_bad = 1'b1;
          end
        endcase
        if (!RUN_I) begin
          // pausing mid-wait keeps the pointer on the waiting entry
          nxt_state = ST_IDLE;
        end
      end
      ST_DELAY: begin
        if (tick) begin
          nxt_dly = dly_ff - 16'h0001;
          if (dly_ff == 16'h0001) begin
            nxt_step = step_inc;
            nxt_state = ST_FETCH;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      step_ff <= {STEP_W{1'b0}};
      op_ff <= 8'h00;
      val_ff <= 16'h0000;
      dly_ff <= 16'h0000;
      relay_ff <= `WSSE_RST_RELAY;
      dac1_ff <= `WSSE_RST_DAC;
      dac2_ff <= `WSSE_RST_DAC;
      dac3_ff <= `WSSE_RST_DAC;
      dac4_ff <= `WSSE_RST_DAC;
      dac_ld_ff <= 4'h0;
      weld_ff <= 1'b0;
      weld_act_ff <= 1'b0;
      sched_ff <= 8'h00;
      bad_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      op_ff <= nxt_op;
      val_ff <= nxt_val;
      dly_ff <= nxt_dly;
      relay_ff <= nxt_relay;
      dac_ld_ff <= nxt_dac_ld;
      weld_ff <= nxt_weld;
      weld_act_ff <= nxt_weld_act;
      sched_ff <= nxt_sched;
      bad_ff <= nxt_bad;
      // 12-bit code: upper value bits beyond full scale are dropped
      if (nxt_dac_ld[0]) dac1_ff <= val_ff[`WSSE_DAC_MSB:0];
      if (nxt_dac_ld[1]) dac2_ff <= val_ff[`WSSE_DAC_MSB:0];
      if (nxt_dac_ld[2]) dac3_ff <= val_ff[`WSSE_DAC_MSB:0];
      if (nxt_dac_ld[3]) dac4_ff <= val_ff[`WSSE_DAC_MSB:0];
    end
  end

  assign FETCH_ADDR_O = step_ff;
  assign FETCH_REQ_O = (state_ff == ST_FETCH) && RUN_I;
  assign PROGRAM_STEP_O = step_ff;
  assign RELAY_OUTPUT_O = relay_ff;
  assign DAC1_O = dac1_ff;
  assign DAC2_O = dac2_ff;
  assign DAC3_O = dac3_ff;
  assign DAC4_O = dac4_ff;
  assign DAC_LOAD_O = dac_ld_ff;
  assign WELD_START_O = weld_ff;
  assign WELD_USE_ACTIVE_O = weld_act_ff;
  assign WELD_SCHED_O = sched_ff;
  assign BAD_OP_O = bad_ff;
  assign BUSY_O = (state_ff != ST_IDLE);
endmodule // wsse_engine
`default_nettype wire

// >>> verif/wsse_store.sv
/*
  program store model on the far side of the engine fetch port.
  assumes the engine samples valid and entry on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module wsse_store (
  input wire logic [7:0] addr_i,
  input wire logic req_i,
  output logic valid_o,
  output logic [23:0] entry_o
);
  logic [23:0] mem [0:255];
  assign valid_o = req_i;
  // inverted when not asked, so a stale entry never reads as good
  assign entry_o = req_i ? mem[addr_i] : ~mem[addr_i];
endmodule // wsse_store
`default_nettype wire

// >>> verif/wsse_engine_sva.sv
/*
  port assertions for the step engine.
  assumes one clock CLK_I and synchronous active-high RST_I.
*/
`timescale 1ns/1ps
`default_nettype none
module wsse_engine_sva #(
  parameter STEP_W = 8,
  parameter TICK_CYC = 4
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic RUN_I,
  input wire logic [7:0] SWITCH_INPUT_I,
  input wire logic [STEP_W-1:0] FETCH_ADDR_O,
  input wire logic FETCH_REQ_O,
  input wire logic FETCH_VALID_I,
  input wire logic [23:0] FETCH_ENTRY_I,
  input wire logic [STEP_W-1:0] PROGRAM_STEP_O,
  input wire logic [7:0] RELAY_OUTPUT_O,
  input wire logic [11:0] DAC1_O,
  input wire logic [3:0] DAC_LOAD_O,
  input wire logic WELD_START_O,
  input wire logic WELD_USE_ACTIVE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire tk = FETCH_REQ_O && FETCH_VALID_I;
  wire [7:0] op = FETCH_ENTRY_I[23:16];
  a_fetch_exec: assert property (tk |=> !FETCH_REQ_O)
    else $error("fetch not followed by execute");
  // pointer must not move while the fetched entry executes
  a_addr_step: assert property (tk |=> $stable(FETCH_ADDR_O))
    else $error("fetch address moved during execute");
  a_branch_jump: assert property (
    tk && op == 8'h01 && FETCH_ENTRY_I[15:8] != 8'h00
    && FETCH_ENTRY_I[7:0] == 8'h01 ##1 !SWITCH_INPUT_I[0]
    |=> PROGRAM_STEP_O == STEP_W'($past(FETCH_ENTRY_I[15:8], 2)))
    else $error("taken branch did not load target");
  a_nop_next: assert property (
    tk && op == 8'h00 |-> ##2 PROGRAM_STEP_O ==
    STEP_W'($past(PROGRAM_STEP_O, 2) + 1'b1))
    else $error("no-op did not advance by one");
  a_relay_set: assert property (
    tk && op == 8'h03 |-> ##2 RELAY_OUTPUT_O ==
    ($past(RELAY_OUTPUT_O, 2) | $past(FETCH_ENTRY_I[7:0], 2)))
    else $error("relay set wrong");
  a_relay_clr: assert property (
    tk && op == 8'h04 |-> ##2 RELAY_OUTPUT_O ==
    ($past(RELAY_OUTPUT_O, 2) & ~$past(FETCH_ENTRY_I[7:0], 2)))
    else $error("relay clear wrong");
  a_dac_load: assert property (
    tk && op == 8'h06 |-> ##2 DAC_LOAD_O == 4'h1
    && DAC1_O == $past(FETCH_ENTRY_I[11:0], 2))
    else $error("converter 1 load wrong");
  a_weld_go: assert property (
    tk && op == 8'h0a |-> ##2 WELD_START_O &&
    WELD_USE_ACTIVE_O == ($past(FETCH_ENTRY_I[7:0], 2) == 8'h00))
    else $error("weld start wrong");
  a_weld_pulse: assert property (WELD_START_O |=> !WELD_START_O)
    else $error("weld start longer than one cycle");
  a_relay_hold: assert property (
    $changed(RELAY_OUTPUT_O) && !$past(RST_I)
    |-> $changed(PROGRAM_STEP_O))
    else $error("relays moved without a step");
  a_load_single: assert property ($onehot0(DAC_LOAD_O))
    else $error("several converter loads at once");
endmodule // wsse_engine_sva
`default_nettype wire

// >>> verif/tb_top.sv
/*
  self-checking bench for the step engine driving a program store model.
  assumes the store answers each fetch in the cycle it is asked.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TICK = 4;
  logic clk, rst, run, req, valid, weld, use_act, bad, busy;
  logic [7:0] sw, addr, step, relay, sched;
  logic [23:0] entry;
  logic [11:0] dac1, dac2, dac3, dac4;
  logic [3:0] load;
  int n_errors = 0;
  int samples_checked = 0;
  wsse_store store (.addr_i(addr), .req_i(req), .valid_o(valid),
    .entry_o(entry));
  wsse_engine #(.STEP_W(8), .TICK_CYC(TICK)) uut (.CLK_I(clk), .RST_I(rst),
    .RUN_I(run), .SWITCH_INPUT_I(sw), .FETCH_ADDR_O(addr), .FETCH_REQ_O(req),
    .FETCH_VALID_I(valid), .FETCH_ENTRY_I(entry), .PROGRAM_STEP_O(step),
    .RELAY_OUTPUT_O(relay), .DAC1_O(dac1), .DAC2_O(dac2), .DAC3_O(dac3),
    .DAC4_O(dac4), .DAC_LOAD_O(load), .WELD_START_O(weld),
    .WELD_USE_ACTIVE_O(use_act), .WELD_SCHED_O(sched), .BAD_OP_O(bad),
    .BUSY_O(busy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic restart;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic go_to(input logic [7:0] s);
    int i;
    for (i = 0; i < 300 && step !== s; i++) @(negedge clk);
    chk("step", s, step);
  endtask
  task automatic t_outputs;
    store.mem[0] = 24'h000000;
    store.mem[1] = 24'h030081;
    store.mem[2] = 24'h040001;
    store.mem[3] = 24'h060fff;
    store.mem[4] = 24'h070800;
    store.mem[5] = 24'h080c00;
    store.mem[6] = 24'h090400;
    store.mem[7] = 24'h0a0004;
    store.mem[8] = 24'h0a0000;
    store.mem[9] = 24'h010002;
    restart();
    go_to(8'h09);
    chk("relay", 24'h80, relay);
    chk("dac1", 24'hfff, dac1);
    chk("dac2", 24'h800, dac2);
    chk("dac3", 24'hc00, dac3);
    chk("dac4", 24'h400, dac4);
    chk("sched", 24'h04, sched);
    chk("use_active", 24'h1, use_act);
    repeat (10) @(negedge clk);
    chk("stall", 24'h09, step);
    chk("busy", 24'h1, busy);
    sw = 8'h02;
    go_to(8'h0a);
    chk("relay_hold", 24'h80, relay);
  endtask
  task automatic t_branches;
    int n;
    // several bits selected: only the lowest, input 1, is off here
    store.mem[0] = 24'h012801;
    store.mem[40] = 24'h023206;
    store.mem[41] = 24'h020001;
    store.mem[42] = 24'h050003;
    store.mem[43] = 24'h023c80;
    // opcode beyond the supported set is skipped with a one-cycle flag
    store.mem[60] = 24'h0b0000;
    store.mem[61] = 24'h000000;
    sw = 8'h84;
    restart();
    go_to(8'd40);
    go_to(8'd42);
    for (n = 0; n < 100 && step === 8'd42; n++) @(negedge clk);
    chk("delay", 24'h1, n >= 3 * TICK && n <= 3 * TICK + 5);
    go_to(8'd60);
    go_to(8'd61);
    chk("bad_op", 24'h1, bad);
    @(negedge clk);
    chk("bad_op_end", 24'h0, bad);
    // stopping mid-entry finishes the no-op, then the engine idles
    run = 1'b0;
    repeat (2) @(negedge clk);
    chk("busy_off", 24'h0, busy);
    chk("step_kept", 24'h3e, step);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b1;
    sw = 8'h00;
    t_outputs();
    t_branches();
    final_report();
  end
  initial begin
    #(40 * 5000);
    n_errors++;
    final_report();
  end
endmodule // tb_top
bind wsse_engine wsse_engine_sva #(.STEP_W(STEP_W), .TICK_CYC(TICK_CYC))
  chk (.*);
`default_nettype wire
